// file: design/tfc_defs.vh
/*
  Constants of the thermal/fan configuration bank: register offsets,
  field positions, power-on values and timing figures.
  Assumes a 50 MHz system clock.
*/
`ifndef TFC_DEFS_VH
`define TFC_DEFS_VH

`define TFC_ADDR_W         8
`define TFC_OFS_SCAN       8'h02
`define TFC_OFS_POLES      8'h03
`define TFC_OFS_PINFN      8'h04
`define TFC_OFS_RATE       8'h05

`define TFC_RST_SCAN       8'h84
`define TFC_RST_POLES      8'h44
`define TFC_RST_PINFN      8'h00
`define TFC_RST_RATE       8'h07

`define TFC_SCAN_RR        7
`define TFC_SCAN_RSVD      6
`define TFC_SCAN_CH_HI     5
`define TFC_SCAN_CH_LO     4
`define TFC_SCAN_SPLIT     3
`define TFC_SCAN_LINEAR    2
`define TFC_SCAN_NOBOOST   1
`define TFC_SCAN_SWRST     0

`define TFC_PIN_REF        7
`define TFC_PIN_WIN_HI     6
`define TFC_PIN_WIN_LO     4
`define TFC_PIN_XOR        3
`define TFC_PIN_EN_RB      2
`define TFC_PIN_EN_RA      1
`define TFC_PIN_EN_LOC     0

`define TFC_CH_LOCAL       2'h0
`define TFC_CH_REMOTE_A    2'h1
`define TFC_CH_REMOTE_B    2'h2
`define TFC_CH_RESERVED    2'h3

`define TFC_RATE_MAX       4'h9
`define TFC_WIN_MAX        3'h5

`define TFC_CLK_MHZ        50
`define TFC_WIN_BASE_US    250000
`define TFC_RATE_BASE_US   31250
`define TFC_WIN_BASE_CYC   (`TFC_WIN_BASE_US * `TFC_CLK_MHZ)
`define TFC_RATE_BASE_CYC  (`TFC_RATE_BASE_US * `TFC_CLK_MHZ)

`endif

// file: design/tfc_conv_pacer.v
/*
  Conversion pacer: issues conversion starts at the selected rate and
  walks the channels. Expects an already clamped rate code.
*/
`timescale 1ns/10ps
`include "tfc_defs.vh"

module tfc_conv_pacer
#(
  parameter [31:0] RATE_BASE_CYCLES = `TFC_RATE_BASE_CYC
)
(
  input  wire       clk_sys,
  input  wire       reset_n,
  input  wire       roundRobin,
  input  wire [1:0] channelSel,
  input  wire [3:0] rateCode,
  output reg        convStart,
  output reg        scanStart,
  output reg  [1:0] convChannel,
  output reg  [3:0] activeRate
);

  reg  [31:0] count;
  reg  [1:0]  next_channel;
  reg         next_scan;
  wire [31:0] period;

  // Slowest code is 512 times the base period
  assign period = RATE_BASE_CYCLES << (`TFC_RATE_MAX - activeRate);

  always @*
  begin
    if (roundRobin)
    begin
      next_channel = (convChannel == `TFC_CH_REMOTE_B) ?
                     `TFC_CH_LOCAL : convChannel + 2'h1;
      next_scan    = (next_channel == `TFC_CH_LOCAL);
    end
    else
    begin
      next_channel = channelSel;
      next_scan    = 1'b1;
    end
  end

  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count       <= 32'h0;
      convStart   <= 1'b0;
      scanStart   <= 1'b0;
      convChannel <= `TFC_CH_LOCAL;
      activeRate  <= 4'h7;
    end
    else if (count >= period - 32'h1)
    begin
      count       <= 32'h0;
      convStart   <= 1'b1;
      scanStart   <= next_scan;
      convChannel <= next_channel;
      if (next_scan)
        activeRate <= rateCode;
    end
    else
    begin
      count     <= count + 32'h1;
      convStart <= 1'b0;
      scanStart <= 1'b0;
    end
  end

endmodule

// file: design/tfc_config_regs.v
/*
  Configuration bank of the thermal monitor / fan controller: scan
  control, fan pole counts, pin function and window, conversion rate.
  Assumes the management-bus engine presents a single-cycle register
  port on clk_sys, and that lock, timer enable and limit comparisons
  come from logic on the same clock.
*/
// Behaviour
// - Scan bit set cycles all channels; clear converts one channel only.
// - Selector picks local, remote A or remote B; code 3 is unused.
// - Split bit clear gives four points per fan; set gives one table.
// - Speed-style bit set ramps speed linearly; clear uses discrete.
// - Boost-inhibit bit set stops overtemperature fan boost.
// - Writing soft-reset bit restores these registers; bit self-clears.
// - Pole register holds fan two high nibble, fan one low nibble.
// - Pin bit clear gives fault output; set gives overtemp reference.
// - Window field selects 0.25 s to 8 s; codes five to seven 8 s.
// - Pin bit three enables the XOR connectivity test.
// - Per-channel enables drive overtemp output when timer on, over limit.
// - Rate field selects 0.0625 to 32 conversions per second.
// - New rate takes effect only at start of next scan.
// - Power-on values 84, 44, 00, 07; soft reset and lock cover all.
// - While lock bit is set, host writes here are ignored.
// - Timer enable makes overtemp pin timed; output enables need it.
`timescale 1ns/10ps
`include "tfc_defs.vh"

module tfc_config_regs
#(
  parameter [31:0] WIN_BASE_CYCLES  = `TFC_WIN_BASE_CYC,
  parameter [31:0] RATE_BASE_CYCLES = `TFC_RATE_BASE_CYC
)
(
  input  wire       clk_sys,
  input  wire       reset_n,
  input  wire       regWrEn,
  input  wire       regRdEn,
  input  wire [7:0] regAddr,
  input  wire [7:0] regWrData,
  output reg  [7:0] regRdData,
  input  wire       lockActive,
  input  wire       overtempTimerEnable,
  input  wire       localOverLimit,
  input  wire       remoteAOverLimit,
  input  wire       remoteBOverLimit,
  input  wire       overtempLimitHit,
  input  wire       overtempTimerHit,
  output reg        softRestorePulse,
  output wire       roundRobin,
  output wire [1:0] channelSelect,
  output wire       tableSplit,
  output wire       linearSpeed,
  output wire       boostInhibit,
  output reg        fanBoost,
  output wire [3:0] fan2Poles,
  output wire [3:0] fan1Poles,
  output wire       refInputMode,
  output wire       fanFaultOutMode,
  output wire [2:0] overtempOntimeWindow,
  output reg        windowTick,
  output wire       xorTestEnable,
  output wire       remoteBOvertempOutEn,
  output wire       remoteAOvertempOutEn,
  output wire       localOvertempOutEn,
  output reg        overtempSignalDrive,
  output wire [3:0] rateSelect,
  output wire [3:0] activeRate,
  output wire       convStart,
  output wire       scanStart,
  output wire [1:0] convChannel
);

  reg  [7:1]  scanCtl;
  reg  [7:0]  poleCounts;
  reg  [7:0]  pinFunc;
  reg  [3:0]  rateSel;
  reg  [31:0] winCount;
  reg  [2:0]  winCode;
  reg  [7:0]  next_rdData;
  wire        wrAllowed;
  wire        hitScan;
  wire        hitPoles;
  wire        hitPinFn;
  wire        hitRate;
  wire        softRestore;
  wire [3:0]  rateEff;
  wire [1:0]  chanEff;
  wire [31:0] winPeriod;
  wire [2:0]  chanOutEn;
  wire [2:0]  chanOver;
  wire [2:0]  chanFire;
  genvar      gi;

  // Reset images, sliced to the stored widths
  localparam [7:0] RST_SCAN = `TFC_RST_SCAN;
  localparam [7:0] RST_RATE = `TFC_RST_RATE;

  assign wrAllowed = regWrEn & ~lockActive;

  assign hitScan  = (regAddr == `TFC_OFS_SCAN);
  assign hitPoles = (regAddr == `TFC_OFS_POLES);
  assign hitPinFn = (regAddr == `TFC_OFS_PINFN);
  assign hitRate  = (regAddr == `TFC_OFS_RATE);

  assign softRestore = wrAllowed & hitScan &
                       regWrData[`TFC_SCAN_SWRST];

  // Register writes; soft restore wins over the data of its own write
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scanCtl <= RST_SCAN[7:1];
    end
    else if (softRestore)
    begin
      scanCtl <= RST_SCAN[7:1];
    end
    else if (wrAllowed && hitScan)
    begin
      scanCtl <= regWrData[7:1];
    end
  end

  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      poleCounts <= `TFC_RST_POLES;
    end
    else if (softRestore)
    begin
      poleCounts <= `TFC_RST_POLES;
    end
    else if (wrAllowed && hitPoles)
    begin
      poleCounts <= regWrData;
    end
  end

  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pinFunc <= `TFC_RST_PINFN;
    end
    else if (softRestore)
    begin
      pinFunc <= `TFC_RST_PINFN;
    end
    else if (wrAllowed && hitPinFn)
    begin
      pinFunc <= regWrData;
    end
  end

  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rateSel <= RST_RATE[3:0];
    end
    else if (softRestore)
    begin
      rateSel <= RST_RATE[3:0];
    end
    else if (wrAllowed && hitRate)
    begin
      rateSel <= regWrData[3:0];
    end
  end

  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      softRestorePulse <= 1'b0;
    else
      softRestorePulse <= softRestore;
  end

  // Read mux; self-clearing bit and read-only nibble read as zero
  always @*
  begin
    next_rdData = 8'h00;
    case (regAddr)
      `TFC_OFS_SCAN:
        next_rdData = {scanCtl, 1'b0};
      `TFC_OFS_POLES:
        next_rdData = poleCounts;
      `TFC_OFS_PINFN:
        next_rdData = pinFunc;
      `TFC_OFS_RATE:
        next_rdData = {4'h0, rateSel};
      default:
        next_rdData = 8'h00;
    endcase
  end

  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      regRdData <= 8'h00;
    else if (regRdEn)
      regRdData <= next_rdData;
  end

  assign roundRobin = scanCtl[`TFC_SCAN_RR];

  assign channelSelect = scanCtl[`TFC_SCAN_CH_HI:`TFC_SCAN_CH_LO];

  // reserved selector falls back to local
  assign chanEff = (channelSelect == `TFC_CH_RESERVED) ?
                   `TFC_CH_LOCAL : channelSelect;

  assign tableSplit = scanCtl[`TFC_SCAN_SPLIT];

  assign linearSpeed = scanCtl[`TFC_SCAN_LINEAR];

  assign boostInhibit = scanCtl[`TFC_SCAN_NOBOOST];

  // Fan logic holds its last speed whenever fanBoost stays low
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      fanBoost <= 1'b0;
    else
      fanBoost <= ~boostInhibit &
                  (overtempLimitHit | overtempTimerHit);
  end

  assign fan2Poles = poleCounts[7:4];
  assign fan1Poles = poleCounts[3:0];

  assign refInputMode    = pinFunc[`TFC_PIN_REF];
  assign fanFaultOutMode = ~pinFunc[`TFC_PIN_REF];

  assign overtempOntimeWindow = pinFunc[`TFC_PIN_WIN_HI:`TFC_PIN_WIN_LO];

  // codes above four all give 8 s
  always @*
  begin
    if (overtempOntimeWindow > `TFC_WIN_MAX)
      winCode = `TFC_WIN_MAX;
    else
      winCode = overtempOntimeWindow;
  end

  assign winPeriod = WIN_BASE_CYCLES << winCode;

  // Window counter keeps its count when a shorter window is chosen mid-count; past the new end it clears and ticks at the next edge
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      winCount   <= 32'h0;
      windowTick <= 1'b0;
    end
    // window runs only while timed input enabled
    else if (!overtempTimerEnable)
    begin
      winCount   <= 32'h0;
      windowTick <= 1'b0;
    end
    else if (winCount >= winPeriod - 32'h1)
    begin
      winCount   <= 32'h0;
      windowTick <= 1'b1;
    end
    else
    begin
      winCount   <= winCount + 32'h1;
      windowTick <= 1'b0;
    end
  end

  assign xorTestEnable = pinFunc[`TFC_PIN_XOR];

  assign remoteBOvertempOutEn = pinFunc[`TFC_PIN_EN_RB];
  assign remoteAOvertempOutEn = pinFunc[`TFC_PIN_EN_RA];
  assign localOvertempOutEn   = pinFunc[`TFC_PIN_EN_LOC];

  assign chanOutEn = {remoteBOvertempOutEn, remoteAOvertempOutEn,
                      localOvertempOutEn};
  assign chanOver  = {remoteBOverLimit, remoteAOverLimit, localOverLimit};

  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_chan
      assign chanFire[gi] = chanOutEn[gi] & chanOver[gi];
    end
  endgenerate

  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      overtempSignalDrive <= 1'b0;
    else
      // enabled channel over limit, timer on
      overtempSignalDrive <= overtempTimerEnable & (|chanFire);
  end

  assign rateSelect = rateSel;

  // undocumented codes run at the fastest rate
  assign rateEff = (rateSel > `TFC_RATE_MAX) ? `TFC_RATE_MAX : rateSel;

  // pacer applies the rate at scan start
  tfc_conv_pacer
  #(
    .RATE_BASE_CYCLES (RATE_BASE_CYCLES)
  )
  u_pacer
  (
    .clk_sys     (clk_sys),
    .reset_n     (reset_n),
    .roundRobin  (roundRobin),
    .channelSel  (chanEff),
    .rateCode    (rateEff),
    .convStart   (convStart),
    .scanStart   (scanStart),
    .convChannel (convChannel),
    .activeRate  (activeRate)
  );

endmodule

// file: bench/tfc_host_model.sv
/*
  Host model driving the single-cycle register port.
  Assumes callers enter its tasks just after a rising edge.
*/
`timescale 1ns/10ps
module tfc_host_model
(
  input  wire       clk_sys,
  output reg        regWrEn = 1'h0,
  output reg        regRdEn = 1'h0,
  output reg  [7:0] regAddr = 8'h00,
  output reg  [7:0] regWrData = 8'h00,
  input  wire [7:0] regRdData
);
  // Idle edge after each transfer keeps strobes from toggling twice
  task gap_out(input [7:0] a);
    begin
      regAddr = ~a;
      regWrData = ~regWrData;
      @(posedge clk_sys);
      #1;
    end
  endtask

  task wr(input [7:0] a, input [7:0] dt);
    begin
      regAddr = a;
      regWrData = (a == 8'h05) ? {1'h0, dt[6:0]} : dt;
      regWrEn = 1'h1;
      @(posedge clk_sys);
      #1;
      regWrEn = 1'h0;
      gap_out(a);
    end
  endtask

  task rd(input [7:0] a, output [7:0] dt);
    begin
      regAddr = a;
      regRdEn = 1'h1;
      @(posedge clk_sys);
      #1;
      regRdEn = 1'h0;
      dt = regRdData;
      gap_out(a);
    end
  endtask
endmodule

// file: bench/tfc_config_regs_assertions.sv
/*
  Checker for the configuration bank.
  Assumes it is bound to the bank's top module.
*/
`timescale 1ns/10ps
module tfc_config_regs_assertions
(
  input wire       clk_sys,
  input wire       reset_n,
  input wire       regWrEn,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire       lockActive,
  input wire       overtempTimerEnable,
  input wire       softRestorePulse,
  input wire       roundRobin,
  input wire [1:0] channelSelect,
  input wire       tableSplit,
  input wire       linearSpeed,
  input wire       boostInhibit,
  input wire       fanBoost,
  input wire [3:0] fan2Poles,
  input wire [3:0] fan1Poles,
  input wire       refInputMode,
  input wire [3:0] rateSelect,
  input wire [3:0] activeRate,
  input wire       scanStart,
  input wire       overtempSignalDrive
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  wire        wrOk = regWrEn && !lockActive;
  wire [18:0] cfg = {roundRobin, channelSelect, tableSplit, linearSpeed,
                     boostInhibit, fan2Poles, fan1Poles, refInputMode,
                     rateSelect};

  AST_LOCKED: assert property (
    regWrEn && lockActive |=> $stable(cfg)) else $error("locked write");
  AST_SCAN: assert property (
    wrOk && regAddr == 8'h02 && !regWrData[0] |=> cfg[18:13] ==
    {$past(regWrData[7]), $past(regWrData[5:1])}) else $error("scan bits");
  AST_POLES: assert property (
    wrOk && regAddr == 8'h03 |=> {fan2Poles, fan1Poles} == $past(regWrData))
    else $error("pole fields");
  AST_RATE: assert property (
    wrOk && regAddr == 8'h05 |=> rateSelect == $past(regWrData[3:0]))
    else $error("rate field");
  AST_SOFT: assert property (
    wrOk && regAddr == 8'h02 && regWrData[0] |=> softRestorePulse &&
    cfg == {6'h22, 8'h44, 1'h0, 4'h7} ##1 !softRestorePulse)
    else $error("soft restore");
  AST_NOBOOST: assert property (
    boostInhibit && $past(boostInhibit) |-> !fanBoost) else $error("boost");
  AST_OTOFF: assert property (
    !overtempTimerEnable && !$past(overtempTimerEnable) |->
    !overtempSignalDrive) else $error("overtemp drive");
  AST_RATEHOLD: assert property (
    activeRate != $past(activeRate) |-> scanStart || $past(scanStart) ||
    $past(softRestorePulse)) else $error("rate change off scan");
endmodule

bind tfc_config_regs tfc_config_regs_assertions tfc_config_regs_assertions_i
  (.clk_sys, .reset_n, .regWrEn, .regAddr, .regWrData, .lockActive,
   .overtempTimerEnable, .softRestorePulse, .roundRobin, .channelSelect,
   .tableSplit, .linearSpeed, .boostInhibit, .fanBoost, .fan2Poles,
   .fan1Poles, .refInputMode, .rateSelect, .activeRate, .scanStart,
   .overtempSignalDrive);

// file: bench/testbench.sv
/*
  Bench top: design, host model and scenario tasks.
  Assumes shortened window and rate bases.
*/
`timescale 1ns/10ps
module testbench;
  reg        clk_sys = 1'h0;
  reg        reset_n = 1'h0;
  reg        lockActive = 1'h0;
  reg        overtempTimerEnable = 1'h0;
  reg        localOverLimit = 1'h0;
  reg        remoteAOverLimit = 1'h0;
  reg        remoteBOverLimit = 1'h0;
  reg        overtempLimitHit = 1'h0;
  reg        overtempTimerHit = 1'h0;
  wire       regWrEn, regRdEn, softRestorePulse, roundRobin, tableSplit;
  wire       linearSpeed, boostInhibit, fanBoost, refInputMode, scanStart;
  wire       fanFaultOutMode, windowTick, xorTestEnable, convStart;
  wire       remoteBOvertempOutEn, remoteAOvertempOutEn;
  wire       localOvertempOutEn, overtempSignalDrive;
  wire [1:0] channelSelect, convChannel;
  wire [2:0] overtempOntimeWindow;
  wire [3:0] fan2Poles, fan1Poles, rateSelect, activeRate;
  wire [7:0] regAddr, regWrData, regRdData;
  int        mismatches = 0;
  int        compares = 0;
  int        cycles = 0;
  int        n;
  int        ch;
  reg  [7:0] d;

  always #10 clk_sys = ~clk_sys;

  tfc_config_regs #(.WIN_BASE_CYCLES(32'h8), .RATE_BASE_CYCLES(32'h4))
    tfc_config_regs_i (.clk_sys, .reset_n, .regWrEn, .regRdEn, .regAddr,
    .regWrData, .regRdData, .lockActive, .overtempTimerEnable,
    .localOverLimit, .remoteAOverLimit, .remoteBOverLimit,
    .overtempLimitHit, .overtempTimerHit, .softRestorePulse, .roundRobin,
    .channelSelect, .tableSplit, .linearSpeed, .boostInhibit, .fanBoost,
    .fan2Poles, .fan1Poles, .refInputMode, .fanFaultOutMode,
    .overtempOntimeWindow, .windowTick, .xorTestEnable,
    .remoteBOvertempOutEn, .remoteAOvertempOutEn, .localOvertempOutEn,
    .overtempSignalDrive, .rateSelect, .activeRate, .convStart,
    .scanStart, .convChannel);

  tfc_host_model tfc_host_model_i (.clk_sys, .regWrEn, .regRdEn, .regAddr,
    .regWrData, .regRdData);

  task chk(input string nm, input [15:0] ex, input [15:0] got);
    begin
      compares++;
      if (got !== ex)
      begin
        mismatches++;
        $display("MISMATCH %s expected %h seen %h", nm, ex, got);
      end
    end
  endtask

  task put(input [7:0] a, input [7:0] v);
    tfc_host_model_i.wr(a, v);
  endtask

  task get(input [7:0] a, input [7:0] ex);
    begin
      tfc_host_model_i.rd(a, d);
      chk("read", {8'h0, ex}, {8'h0, d});
    end
  endtask

  // Cycles between two pulses of convStart or windowTick, bounded
  task gap(input bit w);
    begin
      n = 0;
      while ((w ? windowTick : convStart) !== 1'h1 && n < 600)
      begin
        @(posedge clk_sys);
        #1;
        n++;
      end
      n = 0;
      do
      begin
        @(posedge clk_sys);
        #1;
        n++;
      end while ((w ? windowTick : convStart) !== 1'h1 && n < 600);
    end
  endtask

  task t_defaults;
    begin
      get(8'h02, 8'h84);
      get(8'h03, 8'h44);
      get(8'h04, 8'h00);
      get(8'h05, 8'h07);
      get(8'h06, 8'h00);
    end
  endtask

  task t_scan;
    begin
      put(8'h02, 8'h4a);
      get(8'h02, 8'h4a);
      chk("split", 1, tableSplit);
      for (ch = 0; ch < 3; ch++)
      begin
        put(8'h02, {2'h0, ch[1:0], 4'h4});
        gap(1'h0);
        chk("channel", ch[15:0], convChannel);
        chk("linear", 1, linearSpeed);
      end
    end
  endtask

  task t_rate;
    begin
      put(8'h05, 8'h3a);
      get(8'h05, 8'h0a);
      gap(1'h0);
      gap(1'h0);
      chk("period", 4, n[15:0]);
      put(8'h05, 8'h08);
      gap(1'h0);
      gap(1'h0);
      chk("period", 8, n[15:0]);
    end
  endtask

  task t_pins;
    begin
      put(8'h04, 8'hb9);
      chk("pins", 16'h29, {refInputMode, fanFaultOutMode, xorTestEnable,
        remoteBOvertempOutEn, remoteAOvertempOutEn, localOvertempOutEn});
      overtempTimerEnable = 1'h1;
      localOverLimit = 1'h1;
      gap(1'h1);
      chk("window", 64, n[15:0]);
      chk("drive", 1, overtempSignalDrive);
      localOverLimit = 1'h0;
      remoteBOverLimit = 1'h1;
      put(8'h04, 8'hf9);
      chk("drive", 0, overtempSignalDrive);
      gap(1'h1);
      gap(1'h1);
      chk("window", 256, n[15:0]);
      localOverLimit = 1'h1;
      overtempTimerEnable = 1'h0;
      put(8'h04, 8'hf9);
      chk("drive", 0, overtempSignalDrive);
    end
  endtask

  task t_boost_lock;
    begin
      overtempTimerHit = 1'h1;
      put(8'h03, 8'h26);
      chk("boost", 1, fanBoost);
      put(8'h02, 8'h02);
      chk("boost", 0, fanBoost);
      lockActive = 1'h1;
      put(8'h03, 8'h88);
      put(8'h02, 8'h01);
      lockActive = 1'h0;
      get(8'h03, 8'h26);
      get(8'h02, 8'h02);
      tfc_host_model_i.wr(8'h02, 8'h01);
      t_defaults;
    end
  endtask

  // Waits for the pulse that opens a round-robin scan
  task wait_scan;
    begin
      n = 0;
      while (scanStart !== 1'h1 && n < 600)
      begin
        @(posedge clk_sys);
        #1;
        n++;
      end
    end
  endtask

  task t_rr;
    begin
      wait_scan;
      put(8'h05, 8'h09);
      chk("held", 16'h7, activeRate);
      wait_scan;
      chk("applied", 16'h9, activeRate);
      chk("wrap", 16'h0, convChannel);
      chk("scan", 16'h1, roundRobin);
    end
  endtask

  task end_of_test;
    begin
      if (mismatches == 0 && compares > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      end_of_test;
    end
  end

  initial
  begin
    repeat (12) @(posedge clk_sys);
    #1;
    reset_n = 1'h1;
    t_defaults;
    t_scan;
    t_rate;
    t_pins;
    t_boost_lock;
    t_rr;
    end_of_test;
  end
endmodule
